// File: core/temp_pkg.sv
package temp_pkg;
    // register map, byte offsets as seen by the pointer
    localparam logic [7:0] ADDR_LOCAL = 8'h00;
    localparam logic [7:0] ADDR_R1_HIGH = 8'h01;
    localparam logic [7:0] ADDR_R1_LOW = 8'h10;
    localparam logic [7:0] ADDR_R2_HIGH = 8'h30;
    localparam logic [7:0] ADDR_R2_LOW = 8'h33;
    localparam logic [7:0] ADDR_CFG1_RD = 8'h03;
    localparam logic [7:0] ADDR_CFG1_WR = 8'h09;
    localparam logic [7:0] ADDR_CFG2 = 8'h24;
    // reset values
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // configuration field positions
    localparam int CFG1_ALIAS_BIT = 3;
    localparam int CFG1_RANGE_BIT = 2;
    localparam int CFG2_LOCK_BIT = 7;
    // raw conversion word: signed, quarter degree per step
    localparam int RAW_W = 12;
    localparam int FRAC_W = 2;
    // low byte keeps its two data bits at the top
    localparam int LOW_FRAC_POS = 6;
    // data format limits, in whole degrees
    localparam logic signed [RAW_W-1:0] BIN_MIN = 12'sh000;
    localparam logic signed [RAW_W-1:0] BIN_MAX = 12'sh07F;
    localparam logic signed [RAW_W-1:0] EXT_MIN = -12'sh040;
    localparam logic signed [RAW_W-1:0] EXT_MAX = 12'sh0BF;
    localparam logic signed [RAW_W-1:0] EXT_OFFSET = 12'sh040;
    // channel numbers used for the conversion sequence
    localparam logic [1:0] CH_LOCAL = 2'h0;
    localparam logic [1:0] CH_R1 = 2'h1;
    localparam logic [1:0] CH_R2 = 2'h2;
    localparam int NUM_CH = 3;
endpackage

// File: core/conv_if.sv
`timescale 1ns/100ps
interface conv_if;
    import temp_pkg::*;
    logic signed [RAW_W-1:0] raw;
    logic ext_range;
    logic [7:0] high;
    logic [FRAC_W-1:0] frac;
    modport user (output raw, output ext_range, input high, input frac);
    modport conv (input raw, input ext_range, output high, output frac);
endinterface

// File: core/temp_format.sv
`timescale 1ns/100ps
module temp_format
    import temp_pkg::*;
(
    // raw result in, formatted bytes out
    conv_if.conv cv
);
    logic signed [RAW_W-1:0] whole;

    // whole degrees, rounded toward minus infinity
    assign whole = cv.raw >>> FRAC_W;

    // clamp and encode; a clamped value carries no fraction
    always_comb begin
        cv.high = RESULT_RESET;
        cv.frac = cv.raw[FRAC_W-1:0];
        if (cv.ext_range) begin
            if (whole < EXT_MIN) begin
                cv.high = RESULT_RESET;
                cv.frac = '0;
            end else if (whole > EXT_MAX) begin
                cv.high = 8'(EXT_MAX + EXT_OFFSET); // [RULE9]
                cv.frac = '0;
            end else begin
                cv.high = 8'(whole + EXT_OFFSET); // [RULE11]
            end
        end else begin
            if (whole < BIN_MIN) begin
                cv.high = 8'(BIN_MIN); // [RULE12]
                cv.frac = '0;
            end else if (whole > BIN_MAX) begin
                cv.high = 8'(BIN_MAX); // [RULE12]
                cv.frac = '0;
            end else begin
                cv.high = 8'(whole); // [RULE11]
            end
        end
    end
endmodule

// File: core/temp_result_regs.sv
// Function
// [RULE1] local result is one 8-bit register, one degree per step
// [RULE2] remote result is 10 bits: high byte plus two bits in a low byte
// [RULE3] local at 0x00, remote one high at 0x01, low at 0x10
// [RULE4] remote two high byte at 0x30, low byte at 0x33
// [RULE5] config bit 3 makes 0x01 and 0x10 return remote two
// [RULE6] low byte uses bits 7 and 6 only, quarter degree steps
// [RULE7] reading a low byte freezes its high byte until that is read
// [RULE8] host reads low byte first, then the high byte
// [RULE9] config bit 2 selects 0..127 or -64..+191 range
// [RULE10] the next conversion after a range change uses the new format
// [RULE11] plain binary normally, offset binary plus 64 in extended range
// [RULE12] binary range saturates: below zero gives 0, above 127 gives 127
// [RULE13] range change leaves limits alone; host reprograms them
// [RULE14] every register is eight bits wide
// [RULE15] first write byte loads the pointer; data and reads use it
// [RULE16] pointer is 0x00 after reset, so a bare read gives local
// [RULE17] only conversions update results; host writes to them do nothing
// [RULE18] all five result registers are 0x00 after reset
// [RULE19] each stored result is compared with its high and low limit
// [RULE20] the alias bit stays writable while configuration is locked
// [RULE21] conversions cycle local, remote one, remote two, storing each
// [RULE22] freeze ends on the high byte read; updates then resume
// [RULE23] upper eight bits to high byte, fraction to low byte bits 7..6
`timescale 1ns/100ps
module temp_result_regs
    import temp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // byte port from the serial engine
    input wire logic ptr_wr,
    input wire logic data_wr,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // conversion results from the adc
    input wire logic conv_valid,
    input wire logic signed [RAW_W-1:0] conv_raw,
    output logic [1:0] conv_chan,
    // limits per channel, index 0 local, 1 and 2 remote
    input wire logic [NUM_CH-1:0][7:0] high_lim,
    input wire logic [NUM_CH-1:0][7:0] low_lim,
    // limit comparison results
    output logic [NUM_CH-1:0] over_high,
    output logic [NUM_CH-1:0] under_low
);
    // reset synchroniser
    logic rst_meta;
    logic rst_n;

    // host visible state
    logic [7:0] ptr;
    logic [7:0] cfg1;
    logic lock;

    // result storage, index by channel
    logic [7:0] high_q [NUM_CH];
    logic [FRAC_W-1:0] frac_q [NUM_CH];
    logic [NUM_CH-1:0] frozen;

    // read path
    logic [7:0] next_rd_data;
    logic [1:0] rd_ch;

    // formatter hookup
    conv_if cv ();

    temp_format u_format (
        .cv(cv.conv)
    );

    // release the async reset cleanly on the clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // channel selected by a host address, after the alias bit
    function automatic logic [1:0] remote_of(input logic [7:0] addr,
                                             input logic alias_on);
        logic [1:0] ch;
        ch = 2'h3;
        if (addr == ADDR_R1_HIGH || addr == ADDR_R1_LOW) begin
            ch = alias_on ? CH_R2 : CH_R1; // [RULE5]
        end else if (addr == ADDR_R2_HIGH || addr == ADDR_R2_LOW) begin
            ch = CH_R2; // [RULE4]
        end
        return ch;
    endfunction

    // true when the address names a remote low byte
    function automatic logic is_low(input logic [7:0] addr);
        return addr == ADDR_R1_LOW || addr == ADDR_R2_LOW;
    endfunction

    // the raw word is formatted with the range bit as it stands now
    assign cv.raw = conv_raw;
    assign cv.ext_range = cfg1[CFG1_RANGE_BIT]; // [RULE10]

    // remote channel named by the pointer, 3 when it names none
    assign rd_ch = remote_of(ptr, cfg1[CFG1_ALIAS_BIT]);

    // address pointer: every write transaction starts with it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= PTR_RESET; // [RULE16]
        end else if (ptr_wr) begin
            ptr <= wr_byte; // [RULE15]
        end
    end

    // configuration 1: alias bit escapes the lock, the rest does not
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1 <= CFG1_RESET;
        end else if (data_wr && ptr == ADDR_CFG1_WR) begin // [RULE15]
            if (lock) begin
                cfg1[CFG1_ALIAS_BIT] <= wr_byte[CFG1_ALIAS_BIT]; // [RULE20]
            end else begin
                cfg1 <= wr_byte; // [RULE9]
            end
        end
    end

    // lock sticks until the next reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock <= 1'b0;
        end else if (data_wr && ptr == ADDR_CFG2 &&
                     wr_byte[CFG2_LOCK_BIT]) begin
            lock <= 1'b1;
        end
    end

    // conversion sequencer: walk the channels, one per stored result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_chan <= CH_LOCAL;
        end else if (conv_valid) begin
            if (conv_chan == CH_R2) begin
                conv_chan <= CH_LOCAL; // [RULE21]
            end else begin
                conv_chan <= conv_chan + 2'h1; // [RULE21]
            end
        end
    end

    // result storage; host writes never reach here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                high_q[i] <= RESULT_RESET; // [RULE18]
                frac_q[i] <= '0; // [RULE18]
            end
        end else if (conv_valid) begin // [RULE17]
            if (conv_chan == CH_LOCAL) begin
                high_q[CH_LOCAL] <= cv.high; // [RULE1]
            end else begin
                // a low read on this very edge must hold the high byte too,
                // or the pair would straddle two conversions
                if (!frozen[conv_chan] && !(rd_req && is_low(ptr) &&
                    rd_ch == conv_chan)) begin
                    high_q[conv_chan] <= cv.high; // [RULE7] [RULE23]
                end
                frac_q[conv_chan] <= cv.frac; // [RULE2] [RULE23]
            end
        end
    end

    // high byte freeze: a low read arms it, the high read releases it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frozen <= '0;
        end else if (rd_req && rd_ch != 2'h3) begin
            if (is_low(ptr)) begin
                frozen[rd_ch] <= 1'b1; // [RULE7]
            end else begin
                frozen[rd_ch] <= 1'b0; // [RULE22]
            end
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        next_rd_data = UNMAPPED_READ;
        if (ptr == ADDR_LOCAL) begin
            next_rd_data = high_q[CH_LOCAL]; // [RULE3] [RULE16]
        end else if (rd_ch != 2'h3 && is_low(ptr)) begin
            next_rd_data = {frac_q[rd_ch], {LOW_FRAC_POS{1'b0}}}; // [RULE6]
        end else if (rd_ch != 2'h3) begin
            next_rd_data = high_q[rd_ch]; // [RULE3] [RULE4]
        end else if (ptr == ADDR_CFG1_RD) begin
            next_rd_data = cfg1;
        end else if (ptr == ADDR_CFG2) begin
            next_rd_data = {lock, 7'h00};
        end
    end

    // read answer one cycle after the request, held until the next
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= next_rd_data; // [RULE14] [RULE15]
            end
        end
    end

    // limit compare on the stored bytes; limits are never rewritten here,
    // so after a range change the host must reload them itself [RULE13]
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    over_high[g] <= 1'b0;
                    under_low[g] <= 1'b0;
                end else begin
                    over_high[g] <= high_q[g] > high_lim[g]; // [RULE19]
                    under_low[g] <= high_q[g] < low_lim[g]; // [RULE19]
                end
            end
        end
    endgenerate
endmodule

// File: sim/regs_props.sv
`timescale 1ns/100ps
module regs_props
    import temp_pkg::*;
(
    // watched ports
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ptr_wr,
    input wire logic data_wr,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic conv_valid,
    input wire logic signed [RAW_W-1:0] conv_raw,
    input wire logic [1:0] conv_chan,
    input wire logic [NUM_CH-1:0][7:0] high_lim,
    input wire logic [NUM_CH-1:0][7:0] low_lim,
    input wire logic [NUM_CH-1:0] over_high,
    input wire logic [NUM_CH-1:0] under_low
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // read port answers exactly once per request
    rd_answer_a: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
    no_stray_a: assert property (!rd_req |=> !rd_valid)
        else $error("stray read answer");
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved");
    // low bytes carry data in bits 7 and 6 only
    low_zero_a: assert property (ptr_wr && (wr_byte == ADDR_R1_LOW ||
        wr_byte == ADDR_R2_LOW) ##1 rd_req |=> rd_data[5:0] == 6'h00)
        else $error("low byte spare bits set");
    // channel sequence local, remote one, remote two
    chan_step_a: assert property (conv_valid |=>
        conv_chan == (($past(conv_chan) == CH_R2) ? CH_LOCAL :
        $past(conv_chan) + 2'h1)) else $error("bad channel step");
    chan_hold_a: assert property (
        !conv_valid |=> $stable(conv_chan)) else $error("channel moved");
    chan_legal_a: assert property (conv_chan != 2'h3)
        else $error("illegal channel");
    // ordered local limits can never flag both ways at once
    flags_excl_a: assert property (high_lim[0] >= low_lim[0] &&
        $stable(high_lim) && $stable(low_lim) |->
        !(over_high[0] && under_low[0])) else $error("both flags set");
endmodule
bind temp_result_regs regs_props regs_props_inst (.ref_clk, .nrst,
    .ptr_wr, .data_wr, .wr_byte, .rd_req, .rd_data, .rd_valid,
    .conv_valid, .conv_raw, .conv_chan, .high_lim, .low_lim,
    .over_high, .under_low);

// File: sim/host_model.sv
`timescale 1ns/100ps
module host_model (
    // clock and read answer
    input wire logic ref_clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // requests to the register port
    output logic ptr_wr,
    output logic data_wr,
    output logic [7:0] wr_byte,
    output logic rd_req
);
    // idle request lines at time zero
    initial begin
        ptr_wr = 1'b0;
        data_wr = 1'b0;
        wr_byte = 8'hA5;
        rd_req = 1'b0;
    end
    // pointer byte first, data byte next; idle data is inverted
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        ptr_wr <= 1'b1;
        wr_byte <= a;
        @(posedge ref_clk);
        ptr_wr <= 1'b0;
        data_wr <= 1'b1;
        wr_byte <= d;
        @(posedge ref_clk);
        data_wr <= 1'b0;
        wr_byte <= ~d;
    endtask
    // optional pointer byte, then a read with a bounded wait
    task rd(input logic p, input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge ref_clk);
        ptr_wr <= p;
        wr_byte <= a;
        @(posedge ref_clk);
        ptr_wr <= 1'b0;
        wr_byte <= ~a;
        rd_req <= 1'b1;
        @(posedge ref_clk);
        rd_req <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 4);
        if (rd_valid !== 1'b1) begin
            tb.fail_count++;
            tb.end_sim();
        end
        d = rd_data;
    endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/100ps
module tb;
    import temp_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic ptr_wr, data_wr, rd_req, rd_valid;
    logic [7:0] wr_byte, rd_data, v;
    logic conv_valid = 1'b0;
    logic signed [RAW_W-1:0] conv_raw = 12'h000;
    logic [1:0] conv_chan;
    logic [NUM_CH-1:0][7:0] high_lim = {3{8'h20}};
    logic [NUM_CH-1:0][7:0] low_lim = {3{8'h10}};
    logic [NUM_CH-1:0] over_high, under_low;
    int fail_count = 0;
    int total_checks = 0;
    // row: range bit, raw quarter degrees, expected high and low byte
    typedef struct {logic r; logic signed [RAW_W-1:0] raw;
        logic [7:0] hi; logic [7:0] lo;} row_s;
    row_s rows[7] = '{'{1'b0, 12'h067, 8'h19, 8'hC0},
        '{1'b0, -12'sh005, 8'h00, 8'h00}, '{1'b0, 12'h258, 8'h7F, 8'h00},
        '{1'b0, 12'h1FE, 8'h7F, 8'h80}, '{1'b1, -12'sh0DC, 8'h09, 8'h00},
        '{1'b1, 12'h259, 8'hD6, 8'h40}, '{1'b1, -12'sh118, 8'h00, 8'h00}};
    temp_result_regs temp_result_regs_inst (.ref_clk, .nrst, .ptr_wr,
        .data_wr, .wr_byte, .rd_req, .rd_data, .rd_valid, .conv_valid,
        .conv_raw, .conv_chan, .high_lim, .low_lim, .over_high,
        .under_low);
    host_model host_model_inst (.ref_clk, .rd_data, .rd_valid, .ptr_wr,
        .data_wr, .wr_byte, .rd_req);
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        host_model_inst.rd(1'b1, a, v);
        chk(v, exp);
    endtask
    // one conversion result, channel taken from the design's sequence
    task conv(input logic signed [RAW_W-1:0] raw);
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_raw <= raw;
        @(posedge ref_clk);
        conv_valid <= 1'b0;
        conv_raw <= ~raw;
    endtask
    task end_sim;
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // reset values and a host write check first, then the table, then corner cases ending in a mid-run reset
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        host_model_inst.rd(1'b0, 8'h00, v);
        chk(v, 8'h00);
        rchk(ADDR_R1_HIGH, 8'h00);
        rchk(ADDR_R2_LOW, 8'h00);
        rchk(ADDR_R2_HIGH, 8'h00);
        host_model_inst.wr(ADDR_R1_HIGH, 8'h55);
        rchk(ADDR_R1_HIGH, 8'h00);
        foreach (rows[i]) begin
            host_model_inst.wr(ADDR_CFG1_WR, {5'h00, rows[i].r, 2'h0});
            repeat (3) conv(rows[i].raw);
            rchk(ADDR_LOCAL, rows[i].hi);
            rchk(ADDR_R1_LOW, rows[i].lo);
            rchk(ADDR_R1_HIGH, rows[i].hi);
            rchk(ADDR_R2_LOW, rows[i].lo);
            rchk(ADDR_R2_HIGH, rows[i].hi);
            chk({2'h0, over_high, under_low}, {2'h0, {3{rows[i].hi > 8'h20}},
                {3{rows[i].hi < 8'h10}}});
        end
        host_model_inst.wr(ADDR_CFG1_WR, 8'h08);
        conv(12'h028);
        conv(12'h050);
        conv(12'h079);
        rchk(ADDR_R1_LOW, 8'h40);
        host_model_inst.wr(ADDR_CFG1_WR, 8'h00);
        repeat (2) conv(12'h004);
        conv(12'h0C8);
        rchk(ADDR_R2_HIGH, 8'h1E);
        repeat (2) conv(12'h004);
        conv(12'h0C8);
        rchk(ADDR_R2_HIGH, 8'h32);
        rchk(ADDR_R1_HIGH, 8'h01);
        host_model_inst.wr(ADDR_CFG2, 8'h80);
        host_model_inst.wr(ADDR_CFG1_WR, 8'h08);
        rchk(ADDR_R1_HIGH, 8'h32);
        // under lock only the alias bit may move, never the range bit
        host_model_inst.wr(ADDR_CFG1_WR, 8'h0C);
        rchk(ADDR_CFG1_RD, 8'h08);
        // mid-run reset: pointer back to local, results cleared
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        conv(12'h028);
        host_model_inst.rd(1'b0, 8'h00, v);
        chk(v, 8'h0A);
        rchk(ADDR_R2_HIGH, 8'h00);
        rchk(ADDR_R1_LOW, 8'h00);
        end_sim();
    end
endmodule
